// ### core/nbh_host.sv
// host controller driving the flash device bus cycles
// What this block does
// - lower eight lines carry commands, addresses and data; latched at write-strobe rise
// - upper eight lines carry data only, on the 16-bit variant
// - command cycle: select low, command latch high, address latch low, read high
// - address cycle: select low, address latch high, command latch low, read high
// - host sends exactly four address cycles per full address
// - data-in: select and both latches low, read high; each write rise one word
// - during sequential row read, hold select low through busy intervals
// - no command for 1us after power-up; keep write strobe high then
// - hold write-protect low during power-up and power-down
// - ready/busy is open-drain shared; low means some device busy
// - data-out: select low, write high, latches low; read pulses give words
// - address bytes carry bits 0-7, 9-16, 17-24, 25; bit 8 by pointer command
`timescale 1ns/1ps
`default_nettype none
module nbh_host
    import nbh_pkg::*;
#(
    parameter int unsigned BUS_WIDTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire nbh_req_type req,
    input wire logic hold_select,
    input wire logic power_good,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output nbh_rsp_type rsp,
    output logic device_busy,
    output logic chip_select_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic write_protect_n,
    output logic [15:0] shared_bus_out,
    output logic shared_bus_low_oe,
    output logic shared_bus_high_oe,
    input wire logic [15:0] shared_bus_in,
    input wire logic ready_busy_od
);
    if (BUS_WIDTH != 8 && BUS_WIDTH != 16) begin : g_bad_width
        $error("BUS_WIDTH must be 8 or 16");
    end

    localparam logic [7:0] LOW_CNT = 8'(STROBE_LOW_CYC - 1);
    localparam logic [7:0] HIGH_CNT = 8'(STROBE_HIGH_CYC - 1);
    localparam logic [7:0] RECOV_CNT = 8'(RECOVERY_CYC - 1);

    // address byte for step n of the four address cycles
    function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [1:0] n);
        logic [7:0] b;
        b = 8'h00;
        case (n)
            2'd0: b = a[7:0];
            2'd1: b = a[16:9];
            2'd2: b = a[24:17];
            default: b = {7'h00, a[ADDR_TOP_POS]};
        endcase
        return b;
    endfunction : addr_byte

    // pins sampled through two flops
    logic rb_s1_q, rb_s2_q;
    logic [15:0] din_s1_q, din_s2_q;
    logic pg_s1_q, pg_s2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
            pg_s1_q <= 1'b0;
            pg_s2_q <= 1'b0;
        end else if (ce) begin
            rb_s1_q <= ready_busy_od;
            rb_s2_q <= rb_s1_q;
            din_s1_q <= shared_bus_in;
            din_s2_q <= din_s1_q;
            pg_s1_q <= power_good;
            pg_s2_q <= pg_s1_q;
        end
    end

    nbh_state_type st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    nbh_req_type cur_q, cur_d;
    logic [1:0] astep_q, astep_d;
    logic cs_n_q, cs_n_d, cle_q, cle_d, ale_q, ale_d;
    logic we_n_q, we_n_d, re_n_q, re_n_d, wp_n_q, wp_n_d;
    logic [15:0] dout_q, dout_d;
    logic oel_q, oel_d, oeh_q, oeh_d;
    logic rdy_q, rdy_d, busy_q, busy_d;
    logic cap_valid;
    logic buf_ready;
    logic [15:0] cap_data;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        astep_d = astep_q;
        cs_n_d = cs_n_q;
        cle_d = cle_q;
        ale_d = ale_q;
        we_n_d = we_n_q;
        re_n_d = re_n_q;
        wp_n_d = wp_n_q;
        dout_d = dout_q;
        oel_d = oel_q;
        oeh_d = oeh_q;
        rdy_d = 1'b0;
        cap_valid = 1'b0;
        cap_data = 16'h0000;
        busy_d = ~rb_s2_q;
        case (st_q)
            ST_RECOVER: begin
                wp_n_d = 1'b0;
                we_n_d = 1'b1;
                if (!pg_s2_q) begin
                    cnt_d = RECOV_CNT;
                end else if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    st_d = ST_IDLE;
                    rdy_d = 1'b1;
                    cs_n_d = ~hold_select;
                end
            end
            ST_IDLE: begin
                rdy_d = 1'b1;
                cle_d = 1'b0;
                ale_d = 1'b0;
                oel_d = 1'b0;
                oeh_d = 1'b0;
                wp_n_d = 1'b1;
                // select stays low when the user holds it
                cs_n_d = ~hold_select;
                if (!pg_s2_q) begin
                    st_d = ST_RECOVER;
                    cnt_d = RECOV_CNT;
                    cs_n_d = 1'b1;
                    rdy_d = 1'b0;
                end else if (req_valid && rdy_q) begin
                    cur_d = req;
                    astep_d = 2'd0;
                    rdy_d = 1'b0;
                    cs_n_d = 1'b0;
                    // protect, high while idle, drops low for this cycle unless program/erase asked
                    wp_n_d = req.prog_erase;
                    case (req.op)
                        OP_COMMAND: begin
                            cle_d = 1'b1;
                            ale_d = 1'b0;
                            dout_d = {8'h00, req.data[7:0]};
                            oel_d = 1'b1;
                        end
                        OP_ADDRESS: begin
                            cle_d = 1'b0;
                            ale_d = 1'b1;
                            dout_d = {8'h00, addr_byte(req.addr, 2'd0)};
                            oel_d = 1'b1;
                        end
                        OP_WRITE: begin
                            dout_d = req.data;
                            oel_d = 1'b1;
                            oeh_d = (BUS_WIDTH == 16);
                        end
                        default: begin
                            oel_d = 1'b0;
                        end
                    endcase
                    st_d = ST_SETUP;
                    cnt_d = HIGH_CNT;
                end
            end
            ST_SETUP: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    st_d = ST_LOW;
                    cnt_d = LOW_CNT;
                    if (cur_q.op == OP_READ) begin
                        re_n_d = 1'b0;
                    end else begin
                        we_n_d = 1'b0;
                    end
                end
            end
            ST_LOW: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (cur_q.op == OP_READ && !buf_ready) begin
                    cnt_d = 8'h00;
                end else begin
                    if (cur_q.op == OP_READ) begin
                        cap_valid = 1'b1;
                        cap_data = (BUS_WIDTH == 16) ? din_s2_q : {8'h00, din_s2_q[7:0]};
                    end
                    re_n_d = 1'b1;
                    we_n_d = 1'b1;
                    st_d = ST_HIGH;
                    cnt_d = HIGH_CNT;
                end
            end
            ST_HIGH: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (cur_q.op == OP_ADDRESS && astep_q != 2'(ADDR_CYCLES - 1)) begin
                    astep_d = astep_q + 2'd1;
                    dout_d = {8'h00, addr_byte(cur_q.addr, astep_q + 2'd1)};
                    st_d = ST_SETUP;
                    cnt_d = 8'h00;
                end else begin
                    st_d = ST_IDLE;
                    // deselect at once unless the user holds select
                    cs_n_d = ~hold_select;
                    cle_d = 1'b0;
                    ale_d = 1'b0;
                    oel_d = 1'b0;
                    oeh_d = 1'b0;
                    rdy_d = 1'b1;
                end
            end
            default: st_d = ST_RECOVER;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= ST_RECOVER;
            cnt_q <= RECOV_CNT;
            cur_q <= '0;
            astep_q <= 2'd0;
            cs_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            wp_n_q <= 1'b0;
            dout_q <= 16'h0000;
            oel_q <= 1'b0;
            oeh_q <= 1'b0;
            rdy_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
            astep_q <= astep_d;
            cs_n_q <= cs_n_d;
            cle_q <= cle_d;
            ale_q <= ale_d;
            we_n_q <= we_n_d;
            re_n_q <= re_n_d;
            wp_n_q <= wp_n_d;
            dout_q <= dout_d;
            oel_q <= oel_d;
            oeh_q <= oeh_d;
            rdy_q <= rdy_d;
            busy_q <= busy_d;
        end
    end

    logic out_v;
    logic [15:0] out_w;
    logic rsp_valid_q;
    logic [15:0] rsp_q;
    logic take;

    nbh_skid #(.WIDTH(16)) u_skid (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .in_valid(cap_valid),
        .in_ready(buf_ready),
        .in_data(cap_data),
        .out_valid(out_v),
        .out_ready(take),
        .out_data(out_w)
    );

    // output register stage so rsp comes from flops
    always_comb begin
        take = out_v && (!rsp_valid_q || rsp_ready);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= 16'h0000;
        end else if (ce) begin
            if (take) begin
                rsp_valid_q <= 1'b1;
                rsp_q <= out_w;
            end else if (rsp_ready) begin
                rsp_valid_q <= 1'b0;
            end
        end
    end

    assign req_ready = rdy_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp.data = rsp_q;
    assign device_busy = busy_q;
    assign chip_select_n = cs_n_q;
    assign cmd_latch = cle_q;
    assign addr_latch = ale_q;
    assign write_strobe_n = we_n_q;
    assign read_strobe_n = re_n_q;
    assign write_protect_n = wp_n_q;
    assign shared_bus_out = dout_q;
    assign shared_bus_low_oe = oel_q;
    assign shared_bus_high_oe = oeh_q;
endmodule : nbh_host
`default_nettype wire

// ### core/nbh_pkg.sv
// package: shared constants, types and states of the flash bus host
package nbh_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned RECOVERY_NS = 1000;
    localparam int unsigned RECOVERY_CYC = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STROBE_LOW_CYC = 6;
    localparam int unsigned STROBE_HIGH_CYC = 4;
    localparam int unsigned ADDR_CYCLES = 4;
    localparam int unsigned PAGES_PER_BLOCK = 32;
    localparam int unsigned HALF_PAGE_BYTES = 256;
    localparam int unsigned SPARE_BYTES_X8 = 16;
    localparam int unsigned MAIN_WORDS_X16 = 256;
    localparam int unsigned SPARE_WORDS_X16 = 8;
    localparam logic [7:0] PTR_CMD_LOW_HALF = 8'h00;
    localparam logic [7:0] PTR_CMD_HIGH_HALF = 8'h01;
    localparam int unsigned ADDR_BIT8_POS = 8;
    localparam int unsigned ADDR_TOP_POS = 25;

    typedef enum logic [1:0] {
        OP_COMMAND = 2'b00,
        OP_ADDRESS = 2'b01,
        OP_WRITE = 2'b10,
        OP_READ = 2'b11
    } nbh_op_type;

    typedef struct packed {
        nbh_op_type op;
        logic [15:0] data;
        logic [25:0] addr;
        logic prog_erase;
    } nbh_req_type;

    typedef struct packed {
        logic [15:0] data;
    } nbh_rsp_type;

    typedef enum logic [2:0] {
        ST_RECOVER = 3'b000,
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_LOW = 3'b011,
        ST_HIGH = 3'b100
    } nbh_state_type;
endpackage : nbh_pkg

// ### core/nbh_skid.sv
// two-entry valid/ready buffer for read words
`timescale 1ns/1ps
`default_nettype none
module nbh_skid
    import nbh_pkg::*;
#(
    parameter int unsigned WIDTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid && (cnt_q != 2'd2);
        pop = out_ready && (cnt_q != 2'd0);
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 2'd0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            mem_q <= mem_d;
        end
    end

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
endmodule : nbh_skid
`default_nettype wire

// ### verification/nbh_host_asserts.sv
// pin-level checker for the flash bus host
`timescale 1ns/1ps
`default_nettype none
module nbh_host_asserts
    import nbh_pkg::*;
#(
    parameter int unsigned BUS_WIDTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire nbh_req_type req,
    input wire logic hold_select,
    input wire logic power_good,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire nbh_rsp_type rsp,
    input wire logic device_busy,
    input wire logic chip_select_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_protect_n,
    input wire logic [15:0] shared_bus_out,
    input wire logic shared_bus_low_oe,
    input wire logic shared_bus_high_oe,
    input wire logic [15:0] shared_bus_in,
    input wire logic ready_busy_od
);
    logic [11:0] up_q;
    logic [11:0] up_d;
    // cycles since reset or power loss, saturating
    always_comb begin
        up_d = up_q + {11'h000, up_q != 12'hFFF};
        if (srst || !power_good) begin
            up_d = 12'h000;
        end
    end
    always_ff @(posedge clk) begin
        up_q <= up_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_cmd;
        cmd_latch |-> !addr_latch && !chip_select_n && read_strobe_n;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command pins wrong");
    property p_addr;
        addr_latch |-> !cmd_latch && !chip_select_n && read_strobe_n;
    endproperty
    a_addr: assert property (p_addr) else $error("address pins wrong");
    property p_capture;
        $rose(write_strobe_n) |-> $stable(shared_bus_out) && shared_bus_low_oe && !chip_select_n;
    endproperty
    a_capture: assert property (p_capture) else $error("bus moved at write rise");
    property p_upper;
        (cmd_latch || addr_latch) && !write_strobe_n |-> !shared_bus_high_oe;
    endproperty
    a_upper: assert property (p_upper) else $error("upper lines driven");
    property p_din;
        !write_strobe_n && !cmd_latch && !addr_latch |-> read_strobe_n && !chip_select_n;
    endproperty
    a_din: assert property (p_din) else $error("data-in pins wrong");
    property p_dout;
        !read_strobe_n |-> write_strobe_n && !cmd_latch && !addr_latch && !shared_bus_low_oe;
    endproperty
    a_dout: assert property (p_dout) else $error("data-out pins wrong");
    property p_width;
        $fell(write_strobe_n) |-> !write_strobe_n [*6] ##1 write_strobe_n;
    endproperty
    a_width: assert property (p_width) else $error("write strobe width");
    property p_recover;
        $rose(req_ready) |-> up_q >= RECOVERY_CYC;
    endproperty
    a_recover: assert property (p_recover) else $error("ready before recovery");
    property p_quiet;
        up_q > 12'h004 && up_q < RECOVERY_CYC |-> write_strobe_n && !write_protect_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pins active in recovery");
    property p_busy;
        !ready_busy_od [*4] |-> device_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not seen");
    property p_hold;
        hold_select [*3] ##0 req_ready |-> !chip_select_n;
    endproperty
    a_hold: assert property (p_hold) else $error("select not held");
    property p_standby;
        !hold_select [*3] ##0 req_ready |-> chip_select_n && !shared_bus_low_oe;
    endproperty
    a_standby: assert property (p_standby) else $error("not deselected");
    property p_rsp;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp);
    endproperty
    a_rsp: assert property (p_rsp) else $error("read word lost");
endmodule : nbh_host_asserts
bind nbh_host nbh_host_asserts #(.BUS_WIDTH(BUS_WIDTH)) u_chk (.*);
`default_nettype wire

// ### verification/nbh_flash_model.sv
// behavioural flash device answering the host bus cycles
`timescale 1ns/1ps
`default_nettype none
module nbh_flash_model
    import nbh_pkg::*;
#(
    parameter int unsigned BUSY_CYC = 30,
    parameter int unsigned WIDE = 0
) (
    input wire logic clk,
    input wire logic chip_select_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_protect_n,
    input wire logic [15:0] bus_out,
    output logic [15:0] bus_in,
    output logic rb_od,
    output logic cap_valid,
    output logic [1:0] cap_kind,
    output logic [7:0] cap_data,
    output logic cap_wp
);
    logic we_q = 1'b1;
    logic re_q = 1'b1;
    logic [15:0] word = 16'h0000;
    int col = 0;
    int busy = 0;
    int page = 0;
    int acnt = 0;
    initial begin
        cap_valid = 1'b0;
    end
    always @(posedge clk) begin
        cap_valid <= 1'b0;
        // both latches high is no cycle at all
        if (write_strobe_n && !we_q && !chip_select_n && !(cmd_latch && addr_latch)) begin
            cap_valid <= read_strobe_n;
            cap_kind <= cmd_latch ? 2'd0 : (addr_latch ? 2'd1 : 2'd2);
            cap_data <= bus_out[7:0];
            cap_wp <= write_protect_n;
            if (cmd_latch) begin
                col <= 0;
                acnt <= 0;
            end
            // second address byte holds the page bits
            if (addr_latch) begin
                if (acnt == 1) begin
                    page <= int'(bus_out[7:0]) % PAGES_PER_BLOCK;
                end
                acnt <= (acnt + 1) % ADDR_CYCLES;
            end
            if (cmd_latch && write_protect_n && bus_out[7:0] inside {8'h10, 8'hD0}) begin
                busy <= BUSY_CYC;
            end
        end
        if (!read_strobe_n && re_q && !chip_select_n) begin
            word <= {8'h00, 8'h5A ^ col[7:0] ^ page[7:0]};
            col <= (col + 1) % ((WIDE != 0) ? MAIN_WORDS_X16 + SPARE_WORDS_X16 :
                2 * HALF_PAGE_BYTES + SPARE_BYTES_X8);
        end
        // busy runs on whatever select does
        if (busy > 0) begin
            busy <= busy - 1;
        end
        we_q <= write_strobe_n;
        re_q <= read_strobe_n;
    end
    // released lines show the inverse of the last word
    assign bus_in = (!chip_select_n && !read_strobe_n) ? {~word[15:8], word[7:0]} : ~word;
    assign rb_od = (busy > 0) ? 1'b0 : 1'b1;
endmodule : nbh_flash_model
`default_nettype wire

// ### verification/nbh_host_tb.sv
// self-checking bench for the flash bus host
`timescale 1ns/1ps
`default_nettype none
module nbh_host_tb;
    import nbh_pkg::*;
    logic clk, srst, req_valid, req_ready, hold_select, power_good, rsp_valid, rsp_ready;
    logic device_busy, chip_select_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
    logic write_protect_n, low_oe, high_oe, rb_od, cap_valid, cap_wp, stall, seen;
    logic [15:0] bus_out, bus_in;
    logic [1:0] cap_kind;
    logic [7:0] cap_data;
    logic [31:0] rs = 32'd91;
    logic [31:0] r;
    nbh_req_type req;
    nbh_rsp_type rsp;
    logic [10:0] cq[$];
    logic [15:0] rq[$];
    int err_count = 0;
    int comparisons = 0;
    int rd_n = 0;
    int pg = 0;
    int cycles = 0;
    nbh_host DUT (.clk(clk), .srst(srst), .ce(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .hold_select(hold_select), .power_good(power_good),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .device_busy(device_busy),
        .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .write_protect_n(write_protect_n), .shared_bus_out(bus_out), .shared_bus_low_oe(low_oe),
        .shared_bus_high_oe(high_oe), .shared_bus_in(bus_in), .ready_busy_od(rb_od));
    nbh_flash_model u_flash (.clk(clk), .chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
        .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .write_protect_n(write_protect_n), .bus_out(bus_out), .bus_in(bus_in), .rb_od(rb_od),
        .cap_valid(cap_valid), .cap_kind(cap_kind), .cap_data(cap_data), .cap_wp(cap_wp));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic send(input nbh_op_type op, input logic [15:0] d, input logic [25:0] a,
            input logic pe);
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        case (op)
            OP_COMMAND: begin
                cq.push_back({2'd0, d[7:0], pe});
                rd_n = 0;
            end
            OP_ADDRESS: begin
                cq.push_back({2'd1, a[7:0], pe});
                cq.push_back({2'd1, a[16:9], pe});
                cq.push_back({2'd1, a[24:17], pe});
                cq.push_back({2'd1, 7'h00, a[25], pe});
                pg = a[13:9] % PAGES_PER_BLOCK;
            end
            OP_WRITE: cq.push_back({2'd2, d[7:0], pe});
            default: begin
                rq.push_back({8'h00, 8'h5A ^ rd_n[7:0] ^ pg[7:0]});
                rd_n++;
            end
        endcase
        req_valid = 1'b1;
        req = '{op: op, data: d, addr: a, prog_erase: pe};
        @(negedge clk);
        req_valid = 1'b0;
    endtask : send
    task automatic drain(input string name);
        int n;
        n = 0;
        while (cq.size() + rq.size() > 0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check(cq.size() + rq.size(), 32'h0);
        $display("test %s done", name);
    endtask : drain
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cap_valid === 1'b1) begin
            if (cq.size() == 0) cq.push_back(11'h7FF);
            check({21'h0, cap_kind, cap_data, cap_wp}, {21'h0, cq.pop_front()});
        end
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            if (rq.size() == 0) rq.push_back(16'hFFFF);
            check({16'h0, rsp.data}, {16'h0, rq.pop_front()});
        end
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    always @(negedge clk) begin
        rsp_ready <= !stall && (rnd() % 3 != 0);
    end
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        hold_select = 1'b0;
        power_good = 1'b1;
        rsp_ready = 1'b1;
        stall = 1'b0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        check({29'h0, chip_select_n, write_protect_n, low_oe}, 32'h4);
        send(OP_COMMAND, 16'h0000, 26'h0, 1'b0);
        r = rnd();
        send(OP_ADDRESS, 16'h0000, r[25:0], 1'b0);
        send(OP_ADDRESS, 16'h0000, 26'h3FFFFFF, 1'b0);
        drain("address");
        for (int pe = 0; pe < 2; pe++) begin
            send(OP_COMMAND, 16'h0080, 26'h0, pe[0]);
            r = rnd();
            send(OP_ADDRESS, 16'h0000, r[25:0], pe[0]);
            repeat (3) begin
                r = rnd();
                send(OP_WRITE, r[15:0], 26'h0, pe[0]);
            end
            hold_select = pe[0];
            send(OP_COMMAND, 16'h0010, 26'h0, pe[0]);
            seen = 1'b0;
            repeat (60) begin
                @(negedge clk);
                seen = seen | device_busy;
            end
            check({31'h0, seen}, {31'h0, pe[0]});
            hold_select = 1'b0;
        end
        drain("program");
        stall = 1'b1;
        fork
            begin
                repeat (90) @(negedge clk);
                stall = 1'b0;
            end
        join_none
        send(OP_COMMAND, 16'h0000, 26'h0, 1'b0);
        send(OP_ADDRESS, 16'h0000, 26'h0000E00, 1'b0);
        repeat (6) send(OP_READ, 16'h0000, 26'h0, 1'b0);
        drain("read");
        while (req_ready !== 1'b1) @(negedge clk);
        power_good = 1'b0;
        repeat (5) @(negedge clk);
        check({31'h0, req_ready}, 32'h0);
        power_good = 1'b1;
        send(OP_COMMAND, 16'h0070, 26'h0, 1'b0);
        drain("power");
        complete_run();
    end
endmodule : nbh_host_tb
`default_nettype wire
